/* hdl/pmi_port.sv */
// phy management indirect port: data and command registers driving
// a clause 22 style management frame to the internal phys
// assumes one clock, synchronous active-low reset, mdio pad outside
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
module pria_port #(
	parameter logic [4:0] PHY_A = pria_pkg::PHY_A_DEF,
	parameter logic [4:0] PHY_B = pria_pkg::PHY_B_DEF,
	parameter int MDC_DIV = pria_pkg::MDC_DIV_DEF
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic mdc,
	output logic mdio_out,
	output logic mdio_oe,
	input wire logic mdio_in
);
	// ==========================================
	// registers
	typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_DONE} pria_state_t;
	pria_state_t state_ff;
	logic [15:0] wr_data_ff;
	logic [15:0] rd_data_ff;
	logic [4:0] phy_addr_ff;
	logic [4:0] phy_reg_index_ff;
	logic phy_write_select_ff;
	logic phy_access_pending_ff;
	logic [7:0] div_ff;
	logic [6:0] bit_ff;
	logic [63:0] shift_ff;
	logic [15:0] cap_ff;
	logic mdc_ff;
	logic mdio_out_ff;
	logic mdio_oe_ff;
	logic [31:0] rdata_ff;
	logic [4:0] cmd_phy;
	logic [4:0] cmd_index;
	logic [63:0] frame;
	logic cmd_wr;
	logic data_wr;
	logic launch;
	logic phy_ok;
	logic tick;
	assign cmd_wr = reg_wr && reg_addr == pria_pkg::CMD_OFS;
	assign launch = clk_en && cmd_wr && !phy_access_pending_ff;
	assign data_wr = clk_en && reg_wr && reg_addr == pria_pkg::DATA_OFS && !phy_access_pending_ff;
	assign tick = div_ff == 8'(MDC_DIV - 1);
	assign cmd_phy = reg_wdata[pria_pkg::PHY_ADDR_HI:pria_pkg::PHY_ADDR_LO];
	assign cmd_index = reg_wdata[pria_pkg::REG_IDX_HI:pria_pkg::REG_IDX_LO];
	// only the real phys are valid targets
	assign phy_ok = cmd_phy == PHY_A || cmd_phy == PHY_B;
	// preamble, start, opcode, phy, index, turnaround, data
	assign frame = {32'hFFFFFFFF, 2'h1,
		reg_wdata[pria_pkg::WRITE_SEL_BIT] ? 2'h1 : 2'h2,
		cmd_phy, cmd_index, 2'h2, wr_data_ff};
	// ==========================================
	// data register
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			wr_data_ff <= pria_pkg::DATA_RST;
		else if (data_wr)
			wr_data_ff <= reg_wdata[15:0];
	end
	// ==========================================
	// command register
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			phy_addr_ff <= pria_pkg::FIELD5_RST;
			phy_reg_index_ff <= pria_pkg::FIELD5_RST;
			phy_write_select_ff <= 1'h0;
		end
		else if (launch)
		begin
			phy_addr_ff <= cmd_phy;
			phy_reg_index_ff <= cmd_index;
			phy_write_select_ff <= reg_wdata[pria_pkg::WRITE_SEL_BIT];
		end
	end
	// ==========================================
	// management frame engine and pending flag
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			state_ff <= ST_IDLE;
			phy_access_pending_ff <= 1'h0;
			div_ff <= 8'h00;
			bit_ff <= 7'h00;
			shift_ff <= 64'h0;
			cap_ff <= 16'h0000;
			rd_data_ff <= pria_pkg::DATA_RST;
			mdc_ff <= 1'h0;
			mdio_out_ff <= 1'h1;
			mdio_oe_ff <= 1'h0;
		end
		else if (clk_en)
		begin
			unique case (state_ff)
				ST_IDLE:
				begin
					mdio_oe_ff <= 1'h0;
					if (launch)
					begin
						phy_access_pending_ff <= 1'h1;
						if (phy_ok)
						begin
							state_ff <= ST_SHIFT;
							div_ff <= 8'h00;
							bit_ff <= 7'h00;
							shift_ff <= frame;
							// first bit stands before the first mdc rise
							mdio_out_ff <= frame[63];
							mdio_oe_ff <= 1'h1;
						end
						else
						begin
							// unreachable target reads back all ones
							state_ff <= ST_DONE;
							cap_ff <= 16'hFFFF;
						end
					end
				end
				ST_SHIFT:
				begin
					div_ff <= tick ? 8'h00 : div_ff + 8'h01;
					if (tick)
					begin
						mdc_ff <= ~mdc_ff;
						if (!mdc_ff)
						begin
							// mdc rises: take the bit the phy holds
							cap_ff <= {cap_ff[14:0], mdio_in};
						end
						else if (bit_ff == 7'(pria_pkg::FRAME_BITS - 1))
						begin
							state_ff <= ST_DONE;
							mdio_oe_ff <= 1'h0;
						end
						else
						begin
							// mdc falls: present the next bit, never on a rise
							shift_ff <= {shift_ff[62:0], 1'h0};
							mdio_out_ff <= shift_ff[62];
							// a read hands the line to the phy at the turnaround
							mdio_oe_ff <= phy_write_select_ff
								|| bit_ff < 7'(pria_pkg::TURN_BIT - 1);
							bit_ff <= bit_ff + 7'h01;
						end
					end
				end
				ST_DONE:
				begin
					mdio_oe_ff <= 1'h0;
					mdio_out_ff <= 1'h1;
					if (!phy_write_select_ff)
						rd_data_ff <= cap_ff;
					phy_access_pending_ff <= 1'h0;
					state_ff <= ST_IDLE;
				end
				default:
					state_ff <= ST_IDLE;
			endcase
		end
	end
	// ==========================================
	// register read port
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			rdata_ff <= 32'h0;
		else if (clk_en)
		begin
			rdata_ff <= 32'h0;
			if (reg_rd && reg_addr == pria_pkg::DATA_OFS)
				rdata_ff <= {16'h0000,
					phy_write_select_ff ? wr_data_ff : rd_data_ff};
			else if (reg_rd && reg_addr == pria_pkg::CMD_OFS)
				rdata_ff <= {16'h0000, phy_addr_ff, phy_reg_index_ff, 4'h0,
					phy_write_select_ff, phy_access_pending_ff};
		end
	end
	assign reg_rdata = rdata_ff;
	assign mdc = mdc_ff;
	assign mdio_out = mdio_out_ff;
	assign mdio_oe = mdio_oe_ff;
	// ==========================================
	// checks
	sequence cmd_launch_s;
		clk_en && cmd_wr && !phy_access_pending_ff;
	endsequence
	sequence bad_target_s;
		cmd_launch_s ##0 !phy_ok;
	endsequence
	property pend_set_p;
		@(posedge core_clk) disable iff (!rst_n) cmd_launch_s |=> phy_access_pending_ff;
	endproperty
	pending_set_a: assert property (pend_set_p) else $error("pending not set");
	pending_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && state_ff == ST_DONE |=> !phy_access_pending_ff)
		else $error("pending stuck");
	pending_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		state_ff == ST_SHIFT |-> phy_access_pending_ff)
		else $error("pending dropped during frame");
	data_reset_a: assert property (@(posedge core_clk)
		!rst_n |=> wr_data_ff == pria_pkg::DATA_RST && rd_data_ff == pria_pkg::DATA_RST)
		else $error("data not reset");
	upper_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		reg_rdata[31:16] == 16'h0000)
		else $error("upper bits set");
	data_mux_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && reg_rd && reg_addr == pria_pkg::DATA_OFS |=>
		reg_rdata[15:0] == ($past(phy_write_select_ff) ? $past(wr_data_ff)
		: $past(rd_data_ff)))
		else $error("data mux wrong");
	read_capture_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && state_ff == ST_DONE && !phy_write_select_ff |=> rd_data_ff == $past(cap_ff))
		else $error("read result lost");
	virt_block_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		bad_target_s |=> state_ff == ST_DONE)
		else $error("bad phy reached");
	virt_quiet_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		bad_target_s |=> !mdc_ff && !mdio_oe_ff)
		else $error("frame sent to bad phy");
	read_turn_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		state_ff == ST_SHIFT && !phy_write_select_ff && bit_ff >= 7'(pria_pkg::TURN_BIT)
		|-> !mdio_oe_ff)
		else $error("read drives data phase");
	dir_latch_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		cmd_launch_s |=> phy_write_select_ff == $past(reg_wdata[pria_pkg::WRITE_SEL_BIT])
		&& phy_reg_index_ff == $past(cmd_index))
		else $error("command fields wrong");
endmodule : pria_port

/* hdl/pmi_pkg.sv */
// package for the phy management indirect port
// assumes a 32-bit register port with byte offsets
package pria_pkg;
	// ==========================================
	// register offsets
	localparam logic [11:0] DATA_OFS = 12'h0A4;
	localparam logic [11:0] CMD_OFS = 12'h0A8;
	// ==========================================
	// command register fields
	localparam int PHY_ADDR_HI = 15;
	localparam int PHY_ADDR_LO = 11;
	localparam int REG_IDX_HI = 10;
	localparam int REG_IDX_LO = 6;
	localparam int WRITE_SEL_BIT = 1;
	localparam int PENDING_BIT = 0;
	// ==========================================
	// reset values
	localparam logic [15:0] DATA_RST = 16'h0000;
	localparam logic [4:0] FIELD5_RST = 5'h00;
	// ==========================================
	// phy addresses that reach a real internal phy
	localparam logic [4:0] PHY_A_DEF = 5'h01;
	localparam logic [4:0] PHY_B_DEF = 5'h02;
	// ==========================================
	// management cycle timing
	localparam int MDC_DIV_DEF = 5;
	localparam int FRAME_BITS = 64;
	// first bit of the turnaround, where a read frees the line
	localparam int TURN_BIT = 46;
endpackage : pria_pkg

/* tb/pmi_phy_model.sv */
// phy model: answers 64-bit management frames
// assumes mdio pulled up whenever nobody drives it
`timescale 1ns/1ps
module pria_phy_model (
	input wire logic mdc,
	input wire logic mdio_out,
	input wire logic mdio_oe,
	output logic mdio_in
);
	// ====
	// frame decode and answer
	logic [5:0] cnt = 6'h00;
	logic [62:0] sr;
	logic [13:0] hdr;
	logic [15:0] mem [32];
	logic [15:0] val;
	logic drv = 1'h1;
	assign val = mem[hdr[4:0]] ^ {11'h000, hdr[9:5]};
	assign mdio_in = mdio_oe ? mdio_out : drv;
	always @(posedge mdc)
	begin
		sr <= {sr[61:0], mdio_out};
		cnt <= cnt + 6'h01;
		if (cnt == 6'h2D)
			hdr <= {sr[12:0], mdio_out};
		if (cnt == 6'h3F && hdr[11:10] == 2'h1)
			mem[hdr[4:0]] <= {sr[14:0], mdio_out};
	end
	always @(negedge mdc)
	begin
		if (cnt == 6'h2F)
			drv <= 1'h0;
		else if (cnt >= 6'h30 && hdr[11:10] == 2'h2)
			drv <= val[~cnt[3:0]];
		else
			drv <= 1'h1;
	end
endmodule : pria_phy_model

/* tb/test_phy_register_indirect_access.sv */
// bench for the phy management indirect port
// assumes the phy model in pmi_phy_model.sv
`timescale 1ns/1ps
module test_phy_register_indirect_access;
	// ====
	// harness
	logic core_clk = 1'h0;
	logic rst_n = 1'h0;
	logic [11:0] reg_addr = 12'h000;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'h0;
	logic reg_rd = 1'h0;
	logic clk_en = 1'h1;
	logic [31:0] reg_rdata;
	logic mdc;
	logic mdio_out;
	logic mdio_oe;
	logic mdio_in;
	logic [31:0] got;
	int bad_count = 0;
	int checks_done = 0;
	int cycles = 0;
	pria_port #(.MDC_DIV(1)) pria_port_inst (.core_clk(core_clk), .rst_n(rst_n),
		.clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .mdc(mdc), .mdio_out(mdio_out),
		.mdio_oe(mdio_oe), .mdio_in(mdio_in));
	pria_phy_model pria_phy_model_inst (.mdc(mdc), .mdio_out(mdio_out),
		.mdio_oe(mdio_oe), .mdio_in(mdio_in));
	initial forever #20 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			bad_count = bad_count + 1;
			complete_run();
		end
	end
	task complete_run;
		$display("bad %0d checks %0d", bad_count, checks_done);
		if (bad_count == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks_done = checks_done + 1;
		if (g !== e)
		begin
			bad_count = bad_count + 1;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// ====
	// bus cycles
	task wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'h0;
	endtask : wr
	task rd(input logic [11:0] a);
		@(posedge core_clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'h0;
		#1 got = reg_rdata;
	endtask : rd
	task wait_idle;
		got = 32'h1;
		for (int i = 0; i < 400 && got[0] !== 1'h0; i++)
			rd(pria_pkg::CMD_OFS);
		chk(got & 32'h1, 32'h0);
	endtask : wait_idle
	// ====
	// scenarios
	task t_reset;
		rd(pria_pkg::DATA_OFS);
		chk(got, 32'h0);
		rd(pria_pkg::CMD_OFS);
		chk(got, 32'h0);
		rd(12'h0B0);
		chk(got, 32'h0);
	endtask : t_reset
	task t_write;
		wr(pria_pkg::DATA_OFS, 32'hFFFF1234);
		wr(pria_pkg::CMD_OFS, {16'h0, pria_pkg::PHY_A_DEF, 5'h03, 6'h02});
		rd(pria_pkg::CMD_OFS);
		chk(got, {16'h0, 5'h01, 5'h03, 6'h03});
		wr(pria_pkg::DATA_OFS, 32'h5555);
		wait_idle();
		rd(pria_pkg::DATA_OFS);
		chk(got, 32'h1234);
	endtask : t_write
	task t_read;
		wr(pria_pkg::CMD_OFS, {16'h0, pria_pkg::PHY_B_DEF, 5'h03, 6'h00});
		// freeze the block at the first mdc rise of the frame; the result must survive the stall
		@(posedge core_clk);
		clk_en <= 1'h0;
		repeat (8) @(posedge core_clk);
		clk_en <= 1'h1;
		wait_idle();
		rd(pria_pkg::DATA_OFS);
		chk(got, {16'h0, 16'h1234 ^ {11'h000, pria_pkg::PHY_B_DEF}});
		rd(pria_pkg::CMD_OFS);
		chk(got, {16'h0, 5'h02, 5'h03, 6'h00});
	endtask : t_read
	task t_virt;
		wr(pria_pkg::CMD_OFS, {16'h0, 5'h00, 5'h03, 6'h00});
		wait_idle();
		rd(pria_pkg::DATA_OFS);
		chk(got, 32'h0000FFFF);
	endtask : t_virt
	initial
	begin
		repeat (2) @(posedge core_clk);
		rst_n <= 1'h1;
		t_reset();
		t_write();
		t_read();
		t_virt();
		complete_run();
	end
endmodule : test_phy_register_indirect_access
